//--- tocu_defs.vh
`ifndef TOCU_DEFS_VH
`define TOCU_DEFS_VH

// register indices; the bus byte address is four times the index
`define TOCU_IDX_CORE_INT    10'h00B
`define TOCU_IDX_EVT_FLAGS   10'h00C
`define TOCU_IDX_TMR_LO      10'h00E
`define TOCU_IDX_TMR_HI      10'h00F
`define TOCU_IDX_TMR_CTRL    10'h010
`define TOCU_IDX_CMP_LO      10'h015
`define TOCU_IDX_CMP_HI      10'h016
`define TOCU_IDX_CMP_CTRL    10'h017
`define TOCU_IDX_PORTB_DIR   10'h086
`define TOCU_IDX_EVT_EN      10'h08C

// reset values
`define TOCU_RST_CORE_INT    8'h00
`define TOCU_RST_EVT         8'h00
`define TOCU_RST_TMR_CTRL    8'h00
`define TOCU_RST_CMP_CTRL    8'h00
`define TOCU_RST_PORTB_DIR   8'hFF

// core interrupt control fields
`define TOCU_BIT_GIE         7
`define TOCU_BIT_PERIPHERAL_INTERRUPT_ENABLE        6

// event flag / enable fields
`define TOCU_BIT_TMR_OVF     0
`define TOCU_BIT_CMP_EVT     2
`define TOCU_EVT_MASK        8'h05

// timer control fields
`define TOCU_BIT_TMR_ON      0
`define TOCU_BIT_TMR_EXT     1
`define TOCU_BIT_TMR_NOSYNC  2
`define TOCU_BIT_TMR_OSCEN   3
`define TOCU_TMR_PS_HI       5
`define TOCU_TMR_PS_LO       4
`define TOCU_TMR_CTRL_MASK   8'h3F

// compare control: bits 5:0 implemented, 3:0 is the mode field
`define TOCU_CMP_CTRL_MASK   8'h3F
`define TOCU_MODE_HI         3
`define TOCU_MODE_LO         0

// compare mode codes
`define TOCU_MODE_OFF        4'h0
`define TOCU_MODE_SET_HIGH   4'h8
`define TOCU_MODE_SET_LOW    4'h9
`define TOCU_MODE_SOFT_INT   4'hA
`define TOCU_MODE_SPECIAL    4'hB

// compare pin lands on port b bit 2 or 3
`define TOCU_PIN_BIT_A       2
`define TOCU_PIN_BIT_B       3

`endif

//--- tocu_timer.v
`default_nettype none

module tocu_timer #(
  parameter W = 16
) (
  input wire core_clk, // system clock
  input wire rstn, // async reset, active low
  input wire run, // timer enabled
  input wire ext_sel, // count external edges instead of system clock
  input wire ext_clk_in, // external count input
  input wire [1:0] prescale, // divide by 1, 2, 4 or 8
  input wire load_lo, // write low byte
  input wire load_hi, // write high byte
  input wire [7:0] load_data, // byte to load
  input wire clear, // special-event clear
  output reg [W-1:0] count, // current count
  output reg overflow // one-cycle pulse on wrap to zero
);

  reg ext_d_r;
  reg [2:0] psc_r;
  wire raw_tick;
  wire ps_done;
  wire tick;
  wire [2:0] psc_last;

  // edge of the external input; internal source ticks every cycle
  assign raw_tick = ext_sel ? (ext_clk_in & ~ext_d_r) : 1'b1;
  assign psc_last = (3'h1 << prescale) - 3'h1;
  assign ps_done = (psc_r == psc_last);
  assign tick = run & raw_tick & ps_done;

  ////////////////////////////////////////////////////////////////////////
  // prescaler
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_d_r <= 1'b0;
      psc_r <= 3'h0;
    end else begin
      ext_d_r <= ext_clk_in;
      if (!run || load_lo || load_hi) begin
        psc_r <= 3'h0; // a write also restarts the prescale
      end else if (raw_tick) begin
        psc_r <= ps_done ? 3'h0 : psc_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // count; clear beats a software write, which beats an increment
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= {W{1'b0}};
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (clear) begin
        count <= {W{1'b0}}; // no overflow pulse here
      end else if (load_lo || load_hi) begin
        if (load_lo) begin
          count[7:0] <= load_data;
        end
        if (load_hi) begin
          count[W-1:8] <= load_data[W-9:0];
        end
      end else if (tick) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
        overflow <= &count;
      end
    end
  end

endmodule // tocu_timer

`default_nettype wire

//--- tocu_compare_unit.v
// What this block does
// RULE_01 - compare value is checked against the 16-bit timer count every cycle
// RULE_02 - on a match the mode field drives the pin high, low, or leaves it
// RULE_03 - the compare event flag is set in the same cycle the match acts
// RULE_04 - writing zero to compare control forces the compare latch low only
// RULE_05 - software clears the port direction bit (2 or 3) to enable pin output
// RULE_06 - software runs the timer synchronously when compare mode is used
// RULE_07 - software-interrupt mode leaves the pin alone and only raises the flag
// RULE_08 - special-event match clears the timer and starts a conversion if enabled
// RULE_09 - the special-event timer clear never sets the timer overflow flag
// RULE_10 - compare value bytes have no reset value and survive every reset
// RULE_11 - compare control resets to zero; its top two bits read as zero
// RULE_12 - mode codes: 8 high, 9 low, A interrupt only, B special event
//
// The APB register port is this design's own decision.
`include "tocu_defs.vh"
`default_nettype none

module tocu_compare_unit #(
  parameter TW = 16,
  parameter AW = 12
) (
  input wire core_clk, // system clock, 10 MHz
  input wire rstn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [AW-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire compare_pin_select, // strap: pin on port b bit 3 when high, else bit 2
  input wire timer_ext_clk, // external timer count input
  input wire adc_enabled, // converter is switched on
  output reg adc_start, // one-cycle conversion start
  output reg compare_output_pin_o, // pin level when driven
  output reg compare_output_pin_oe, // pin driven as output
  output reg compare_match, // one-cycle pulse when a match acts
  output reg irq // level interrupt
);

  reg [7:0] core_int_r;
  reg [7:0] evt_flags_r;
  reg [7:0] evt_en_r;
  reg [7:0] tmr_ctrl_r;
  reg [7:0] cmp_ctrl_r;
  reg [7:0] portb_dir_r;
  reg [7:0] cmp_lo_r;
  reg [7:0] cmp_hi_r;
  reg cmp_latch_r;
  reg match_d_r;
  reg pin_sel_r;
  reg [7:0] rd_nxt;
  reg hit_nxt;

  wire [TW-1:0] timer_count;
  wire timer_ovf;
  wire [9:0] idx;
  wire aligned;
  wire wr_acc;
  wire setup;
  wire [7:0] wbyte;
  wire [3:0] mode;
  wire match;
  wire mode_active;
  wire fire;
  wire special_fire;
  wire pin_dir_bit;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when the address is word aligned and names the given index
  function is_reg;
    input [9:0] a_idx;
    input a_ok;
    input [9:0] r_idx;
    begin
      is_reg = a_ok && (a_idx == r_idx);
    end
  endfunction

  // modes that use the compare match at all
  function mode_is_compare;
    input [3:0] m;
    begin
      mode_is_compare = (m == `TOCU_MODE_SET_HIGH) || (m == `TOCU_MODE_SET_LOW) ||
                        (m == `TOCU_MODE_SOFT_INT) || (m == `TOCU_MODE_SPECIAL);
    end
  endfunction

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup = psel & ~penable;
  // writes land only at the edge where the access phase sees pready
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
  assign wbyte = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // timer

  tocu_timer #(
    .W(TW)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(tmr_ctrl_r[`TOCU_BIT_TMR_ON]),
    .ext_sel(tmr_ctrl_r[`TOCU_BIT_TMR_EXT]),
    .ext_clk_in(timer_ext_clk),
    .prescale(tmr_ctrl_r[`TOCU_TMR_PS_HI:`TOCU_TMR_PS_LO]),
    .load_lo(wr_acc && is_reg(idx, aligned, `TOCU_IDX_TMR_LO)),
    .load_hi(wr_acc && is_reg(idx, aligned, `TOCU_IDX_TMR_HI)),
    .load_data(wbyte),
    .clear(special_fire), // [RULE_08]
    .count(timer_count),
    .overflow(timer_ovf)
  );

  ////////////////////////////////////////////////////////////////////////
  // compare engine

  // equality is checked every cycle; only the entry into a match acts,
  // so a stopped timer sitting on the value fires once, not forever
  assign mode = cmp_ctrl_r[`TOCU_MODE_HI:`TOCU_MODE_LO];
  assign match = (timer_count == {cmp_hi_r, cmp_lo_r}); // [RULE_01]
  assign mode_active = mode_is_compare(mode); // [RULE_12]
  assign fire = mode_active & match & ~match_d_r;
  assign special_fire = fire & (mode == `TOCU_MODE_SPECIAL); // [RULE_08]

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      match_d_r <= 1'b0;
    end else begin
      match_d_r <= mode_active & match;
    end
  end

  // compare value: deliberately outside the reset, it powers up unknown
  // and keeps its contents across resets
  always @(posedge core_clk) begin
    if (wr_acc && is_reg(idx, aligned, `TOCU_IDX_CMP_LO)) begin
      cmp_lo_r <= wbyte; // [RULE_10]
    end
    if (wr_acc && is_reg(idx, aligned, `TOCU_IDX_CMP_HI)) begin
      cmp_hi_r <= wbyte; // [RULE_10]
    end
  end

  // compare output latch; a zero control write wins over a match
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_latch_r <= 1'b0;
    end else if (wr_acc && is_reg(idx, aligned, `TOCU_IDX_CMP_CTRL) && wbyte == 8'h00) begin
      cmp_latch_r <= 1'b0; // [RULE_04]
    end else if (fire) begin
      case (mode)
        `TOCU_MODE_SET_HIGH: cmp_latch_r <= 1'b1; // [RULE_02]
        `TOCU_MODE_SET_LOW: cmp_latch_r <= 1'b0; // [RULE_02]
        default: cmp_latch_r <= cmp_latch_r; // [RULE_07]
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_ctrl_r <= `TOCU_RST_CMP_CTRL; // [RULE_11]
      tmr_ctrl_r <= `TOCU_RST_TMR_CTRL;
      portb_dir_r <= `TOCU_RST_PORTB_DIR;
      core_int_r <= `TOCU_RST_CORE_INT;
      evt_en_r <= `TOCU_RST_EVT;
    end else if (wr_acc) begin
      if (is_reg(idx, aligned, `TOCU_IDX_CMP_CTRL)) begin
        cmp_ctrl_r <= wbyte & `TOCU_CMP_CTRL_MASK; // [RULE_11]
      end
      if (is_reg(idx, aligned, `TOCU_IDX_TMR_CTRL)) begin
        tmr_ctrl_r <= wbyte & `TOCU_TMR_CTRL_MASK;
      end
      if (is_reg(idx, aligned, `TOCU_IDX_PORTB_DIR)) begin
        portb_dir_r <= wbyte;
      end
      if (is_reg(idx, aligned, `TOCU_IDX_CORE_INT)) begin
        core_int_r <= wbyte & 8'hC0; // only the two gate bits live here
      end
      if (is_reg(idx, aligned, `TOCU_IDX_EVT_EN)) begin
        evt_en_r <= wbyte & `TOCU_EVT_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags: hardware set beats a write-one clear in the same cycle

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      evt_flags_r <= `TOCU_RST_EVT;
    end else begin
      if (wr_acc && is_reg(idx, aligned, `TOCU_IDX_EVT_FLAGS)) begin
        evt_flags_r <= evt_flags_r & ~(wbyte & `TOCU_EVT_MASK);
      end
      if (fire) begin
        evt_flags_r[`TOCU_BIT_CMP_EVT] <= 1'b1; // [RULE_03] [RULE_07]
      end
      // the timer suppresses its overflow pulse when a special event clears it
      if (timer_ovf) begin
        evt_flags_r[`TOCU_BIT_TMR_OVF] <= 1'b1; // [RULE_09]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin, trigger and interrupt outputs

  // strap sampled every cycle; it is a static configuration level
  assign pin_dir_bit = pin_sel_r ? portb_dir_r[`TOCU_PIN_BIT_B] : portb_dir_r[`TOCU_PIN_BIT_A];

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_sel_r <= 1'b0;
      compare_output_pin_o <= 1'b0;
      compare_output_pin_oe <= 1'b0;
      adc_start <= 1'b0;
      compare_match <= 1'b0;
      irq <= 1'b0;
    end else begin
      pin_sel_r <= compare_pin_select;
      compare_output_pin_o <= cmp_latch_r;
      compare_output_pin_oe <= ~pin_dir_bit; // [RULE_05]
      adc_start <= special_fire & adc_enabled; // [RULE_08]
      compare_match <= fire;
      // one cycle of delay keeps irq straight off a flop
      irq <= core_int_r[`TOCU_BIT_GIE] & core_int_r[`TOCU_BIT_PERIPHERAL_INTERRUPT_ENABLE] &
             (|(evt_flags_r & evt_en_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: data is prepared in the setup cycle so the answer comes
  // from flops with pready high in the first access cycle

  always @* begin
    rd_nxt = 8'h00;
    hit_nxt = aligned;
    case (idx)
      `TOCU_IDX_CORE_INT: rd_nxt = core_int_r;
      `TOCU_IDX_EVT_FLAGS: rd_nxt = evt_flags_r;
      `TOCU_IDX_TMR_LO: rd_nxt = timer_count[7:0];
      `TOCU_IDX_TMR_HI: rd_nxt = timer_count[TW-1:8];
      `TOCU_IDX_TMR_CTRL: rd_nxt = tmr_ctrl_r;
      `TOCU_IDX_CMP_LO: rd_nxt = cmp_lo_r;
      `TOCU_IDX_CMP_HI: rd_nxt = cmp_hi_r;
      `TOCU_IDX_CMP_CTRL: rd_nxt = cmp_ctrl_r; // [RULE_11]
      `TOCU_IDX_PORTB_DIR: rd_nxt = portb_dir_r;
      `TOCU_IDX_EVT_EN: rd_nxt = evt_en_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= (pwrite || !hit_nxt) ? 32'h00000000 : {24'h000000, rd_nxt};
        pslverr <= ~hit_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // tocu_compare_unit

`default_nettype wire

//--- tocu_pin_load.sv
`default_nettype none
// external load on the compare pin; the port's weak pull-up holds it high when released
module tocu_pin_load (
  input wire logic drive_level, // level offered by the unit
  input wire logic drive_en, // unit drives the pin
  output var logic pin_level // resolved wire level
);
  // released pin floats to the pull-up, never to the last driven value
  always_comb pin_level = drive_en ? drive_level : 1'b1;
endmodule // tocu_pin_load
`default_nettype wire

//--- tocu_checker_assertions.sv
`default_nettype none
module tocu_checker #(
  parameter AW = 12
) (
  input wire logic core_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [AW-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic compare_pin_select, // pin strap
  input wire logic timer_ext_clk, // count input
  input wire logic adc_enabled, // converter on
  input wire logic adc_start, // conversion start
  input wire logic compare_output_pin_o, // pin level
  input wire logic compare_output_pin_oe, // pin enable
  input wire logic compare_match, // match pulse
  input wire logic irq // interrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_misaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_rdata_top_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_match_single: assert property (compare_match |=> !compare_match)
    else $error("match pulse too long");
  a_pin_rise_cause: assert property ($rose(compare_output_pin_o) |-> $past(compare_match))
    else $error("pin rose without match");
  a_adc_on_match: assert property (adc_start |-> compare_match && $past(adc_enabled))
    else $error("conversion start without match");
endmodule // tocu_checker
`default_nettype wire

//--- tb_tocu_compare_unit.sv
`include "tocu_defs.vh"
`default_nettype none
module tb_tocu_compare_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, psel, penable, pwrite, pin_sel, ext_clk, adc_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, adc_start, pin_o, pin_oe, cmatch, irq, pin_level;
  logic [7:0] rd;
  int n_mismatch = 0;
  int n_checks = 0;
  int gap, k;
  logic [9:0] ridx [6] = '{`TOCU_IDX_CMP_CTRL, `TOCU_IDX_EVT_FLAGS, `TOCU_IDX_EVT_EN,
    `TOCU_IDX_CORE_INT, `TOCU_IDX_PORTB_DIR, `TOCU_IDX_TMR_CTRL};
  logic [7:0] rval [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  logic [3:0] mode [4] = '{`TOCU_MODE_SET_HIGH, `TOCU_MODE_SOFT_INT, `TOCU_MODE_SET_LOW,
    `TOCU_MODE_SET_HIGH};
  logic pexp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  tocu_compare_unit tocu_compare_unit_i (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_pin_select(pin_sel), .timer_ext_clk(ext_clk),
    .adc_enabled(adc_en), .adc_start(adc_start), .compare_output_pin_o(pin_o),
    .compare_output_pin_oe(pin_oe), .compare_match(cmatch), .irq(irq));
  tocu_pin_load tocu_pin_load_i (.drive_level(pin_o), .drive_en(pin_oe), .pin_level(pin_level));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction
  // one transfer; request held until ready is sampled high, data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic err);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      check(0, 1, "bus timeout");
      report_and_stop;
    end
    rd = prdata[7:0];
    check(pslverr, err, "error response");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // gap returns the edges waited, so two calls measure the match period
  task automatic wait_match;
    gap = 0;
    do begin
      @(posedge core_clk);
      gap++;
    end while (cmatch !== 1'b1 && gap < 300);
    if (cmatch !== 1'b1) begin
      check(0, 1, "match timeout");
      report_and_stop;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, pin_sel, ext_clk, adc_en} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    for (k = 0; k < 6; k++) begin
      apb(0, ba(ridx[k]), 8'h00, 0);
      check(rd, rval[k], "reset value");
    end
    apb(0, 12'h004, 8'h00, 1);
    apb(1, ba(`TOCU_IDX_CMP_CTRL) + 12'h002, 8'hFF, 1); // misaligned, must be refused
    apb(0, ba(`TOCU_IDX_CMP_CTRL), 8'h00, 0);
    check(rd, 8'h00, "misaligned write ignored");
    apb(1, ba(`TOCU_IDX_CMP_CTRL), 8'hFF, 0);
    apb(0, ba(`TOCU_IDX_CMP_CTRL), 8'h00, 0);
    check(rd, 8'h3F, "control top bits");
    apb(1, ba(`TOCU_IDX_CMP_CTRL), 8'h00, 0);
    apb(1, ba(`TOCU_IDX_PORTB_DIR), 8'hFB, 0);
    // the enable is a flop fed from the direction register: one edge of lag after the write edge
    repeat (2) @(posedge core_clk);
    check(pin_oe, 1, "pin enabled");
    apb(1, ba(`TOCU_IDX_EVT_EN), 8'h05, 0);
    apb(1, ba(`TOCU_IDX_CORE_INT), 8'hC0, 0);
    apb(1, ba(`TOCU_IDX_CMP_LO), 8'h10, 0);
    apb(1, ba(`TOCU_IDX_CMP_HI), 8'h00, 0);
    apb(1, ba(`TOCU_IDX_TMR_HI), 8'h00, 0);
    apb(1, ba(`TOCU_IDX_TMR_CTRL), 8'h01, 0);
    // each mode from a fresh low count, so the match comes within a few cycles
    for (k = 0; k < 4; k++) begin
      apb(1, ba(`TOCU_IDX_TMR_LO), 8'h00, 0);
      apb(1, ba(`TOCU_IDX_CMP_CTRL), {4'h0, mode[k]}, 0);
      wait_match;
      @(posedge core_clk);
      check(pin_level, pexp[k], "pin after match");
      apb(0, ba(`TOCU_IDX_EVT_FLAGS), 8'h00, 0);
      check(rd, 8'h04, "compare flag");
      check(irq, 1, "irq raised");
      apb(1, ba(`TOCU_IDX_EVT_EN), 8'h01, 0);
      repeat (2) @(posedge core_clk);
      check(irq, 0, "irq masked");
      apb(1, ba(`TOCU_IDX_EVT_FLAGS), 8'h04, 0);
      apb(1, ba(`TOCU_IDX_EVT_EN), 8'h05, 0);
      repeat (2) @(posedge core_clk);
      check(irq, 0, "irq cleared");
    end
    apb(1, ba(`TOCU_IDX_CMP_CTRL), 8'h00, 0);
    repeat (3) @(posedge core_clk);
    check(pin_level, 0, "latch forced low");
    check(pin_oe, 1, "direction kept");
    pin_sel <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(pin_oe, 0, "pin on bit 3");
    pin_sel <= 1'b0;
    adc_en <= 1'b1;
    apb(1, ba(`TOCU_IDX_TMR_LO), 8'h00, 0);
    apb(1, ba(`TOCU_IDX_CMP_CTRL), {4'h0, `TOCU_MODE_SPECIAL}, 0);
    wait_match;
    check(adc_start, 1, "conversion started");
    wait_match;
    check(gap, 17, "period of compare plus one");
    apb(0, ba(`TOCU_IDX_EVT_FLAGS), 8'h00, 0);
    check(rd, 8'h04, "no overflow flag");
    adc_en <= 1'b0;
    wait_match;
    check(adc_start, 0, "converter off");
    apb(1, ba(`TOCU_IDX_CMP_LO), 8'h5A, 0);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    apb(0, ba(`TOCU_IDX_CMP_LO), 8'h00, 0);
    check(rd, 8'h5A, "value kept over reset");
    apb(0, ba(`TOCU_IDX_CMP_CTRL), 8'h00, 0);
    check(rd, 8'h00, "control reset again");
    report_and_stop;
  end
endmodule // tb_tocu_compare_unit
bind tocu_compare_unit tocu_checker #(.AW(AW)) tocu_checker_i (.core_clk(core_clk),
  .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_pin_select(compare_pin_select), .timer_ext_clk(timer_ext_clk),
  .adc_enabled(adc_enabled), .adc_start(adc_start), .compare_output_pin_o(compare_output_pin_o),
  .compare_output_pin_oe(compare_output_pin_oe), .compare_match(compare_match), .irq(irq));
`default_nettype wire
